// ===== include/rx_page_pkg.sv
// Shared constants for the receive-port paging register slice.
// Assumes a byte-wide register access port decoded by an upstream I2C/control-channel front end.
package rx_page_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_SOURCES = 5;            // Source 0 local I2C, 1..4 control channel of port 0..3
  localparam logic [7:0] ADDR_RESERVED = 8'h49;
  localparam logic [7:0] ADDR_LINK_CAP = 8'h4A;
  localparam logic [7:0] ADDR_RAW_EMBED = 8'h4B;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h4C;
  localparam logic [7:0] ADDR_PORT_STS1 = 8'h4D;
  localparam logic [7:0] PAGED_LO_A = 8'h4D;
  localparam logic [7:0] PAGED_HI_A = 8'h7F;
  localparam logic [7:0] PAGED_LO_B = 8'hD0;
  localparam logic [7:0] PAGED_HI_B = 8'hDF;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [5:0] EMBED_TYPE_RESET = 6'h12;
  localparam logic [1:0] EMBED_COUNT_RESET = 2'h0;
  localparam logic CRC_FLAG_RESET = 1'b0;
  localparam int CRC_FLAG_BIT = 4;
  localparam int EMBED_COUNT_LSB = 6;
  localparam int ARRIVAL_LSB = 6;
  localparam int READ_SEL_LSB = 4;
  localparam int STS_PORT_LSB = 6;
  localparam logic [5:0] RAW10_RESET = 6'h2B;
  localparam logic [5:0] RAW12_RESET = 6'h2C;
endpackage

// ===== hw/rx_port_page_select_regs.sv
// Port paging control, capability bit and raw embedded type substitution.
// Assumes reg_rd/reg_wr are one-cycle strobes from a front end naming the access source.
// What this block does
// (RULE1) The two-bit read selector chooses which of the four port copies answers paged reads.
// (RULE2) Four write-enable bits choose which port copies take a paged write, any combination.
// (RULE3) Paging applies to addresses 0x4D to 0x7F and 0xD0 to 0xDF.
// (RULE4) Control-channel sources default to their own port for read and write; local I2C to zero.
// (RULE5) The arrival-port field reads zero locally and the carrying port number remotely.
// (RULE6) Each access source keeps its own paging state.
// (RULE7) An embedded line count of 0 sends all lines as raw video, 1 to 3 send that many first.
// (RULE8) Substituted lines carry the six-bit embedded type value, reset 0x12.
// (RULE9) Substitution never applies to a port set for CSI-2 formatted input.
// (RULE10) Software should set the encoder CRC flag bit and keep the encoder CRC disable low.
// (RULE11) Location 0x49 reads as 0x00.
// (RULE12) The first per-port status register reports the selected read port in bits 7:6.
// (RULE13) A paged write with no write enable set changes no port copy.
`timescale 1ns/1ps
module rx_port_page_select_regs
  import rx_page_pkg::*;
#(
  parameter int PAGED_WORDS = 67
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_remote,
  input wire logic [1:0] reg_src_port,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  input wire logic [3:0] csi2_mode,
  input wire logic [3:0] frame_start,
  input wire logic [3:0] long_pkt,
  input wire logic [5:0] raw_type_in [NUM_PORTS],
  output logic [5:0] pkt_type_ff [NUM_PORTS],
  output logic [3:0] pkt_embedded_ff,
  output logic [3:0] crc_flag_enable_ff
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Low window is stored first, the high window is stacked right after it
  localparam int LOW_WORDS = int'(PAGED_HI_A - PAGED_LO_A) + 1;
  localparam int HIGH_WORDS = int'(PAGED_HI_B - PAGED_LO_B) + 1;
  localparam int IDX_W = $clog2(PAGED_WORDS);
  // Line counter stops here, so long frames never wrap back into the embedded lines
  localparam logic [1:0] LINE_CNT_MAX = 2'h3;
  // One long packet per step
  localparam logic [1:0] LINE_CNT_STEP = 2'h1;

  // A smaller array would alias the high window onto the low one
  if (PAGED_WORDS < LOW_WORDS + HIGH_WORDS) begin : g_words_check
    $error("PAGED_WORDS too small for both paged windows");
  end
  // One local source plus one control-channel source per port
  if (NUM_SOURCES != NUM_PORTS + 1) begin : g_sources_check
    $error("NUM_SOURCES must be one more than NUM_PORTS");
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  // (RULE3) membership in either paged window
  function automatic logic is_paged(input logic [7:0] a);
    logic lo_hit;
    logic hi_hit;
    lo_hit = (a >= PAGED_LO_A) && (a <= PAGED_HI_A);
    hi_hit = (a >= PAGED_LO_B) && (a <= PAGED_HI_B);
    return lo_hit || hi_hit;
  endfunction

  // Folds both windows into one index with no overlap, so every paged byte stays its own
  function automatic logic [IDX_W-1:0] page_index(input logic [7:0] a);
    int t;
    t = 0;
    if (a <= PAGED_HI_A) begin
      t = int'(a) - int'(PAGED_LO_A);
    end else begin
      t = int'(a) - int'(PAGED_LO_B) + LOW_WORDS;
    end
    return IDX_W'(t);
  endfunction

  // ****************************************
  // Storage and source decode
  // ****************************************
  // Paging state is kept per access source, register copies per receive port
  logic [2:0] src;
  logic [1:0] sel_ff [NUM_SOURCES];
  logic [3:0] wen_ff [NUM_SOURCES];
  logic [5:0] embed_type_ff [NUM_PORTS];
  logic [1:0] embed_count_ff [NUM_PORTS];
  logic [7:0] paged_ff [NUM_PORTS][PAGED_WORDS];
  logic [1:0] line_cnt_ff [NUM_PORTS];
  logic [1:0] rd_port;
  logic [3:0] port_wr;
  logic [3:0] swap;

  // (RULE6) per-source state, local I2C is source 0
  assign src = reg_remote ? (3'h1 + {1'b0, reg_src_port}) : 3'h0;

  // Read copy chosen by the requesting source only
  assign rd_port = sel_ff[src];

  // (RULE2) ports taking this write, any combination
  // (RULE13) no enable set means no port copy moves
  assign port_wr = reg_wr ? wen_ff[src] : 4'h0;

  // ****************************************
  // Paging state
  // ****************************************
  // (RULE4) read selector defaults per source
  // A remote source starts on its own port so it can read back at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < NUM_SOURCES; s++) begin
        sel_ff[s] <= (s == 0) ? 2'h0 : 2'(s - 1);
      end
    end else if (reg_wr && reg_addr == ADDR_PAGE_SEL) begin
      sel_ff[src] <= reg_wdata[READ_SEL_LSB +: 2];
    end
  end

  // (RULE4) write enable defaults per source
  // Local I2C starts with every port locked, so a stray write touches nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < NUM_SOURCES; s++) begin
        wen_ff[s] <= (s == 0) ? 4'h0 : 4'(1 << (s - 1));
      end
    end else if (reg_wr && reg_addr == ADDR_PAGE_SEL) begin
      wen_ff[src] <= reg_wdata[NUM_PORTS-1:0];
    end
  end

  // ****************************************
  // Per-port copies
  // ****************************************
  // Capability bit, which software is expected to set
  // Only bit 4 is stored; the other bits are reserved and read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        crc_flag_enable_ff[p] <= CRC_FLAG_RESET;
      end
    end else if (reg_addr == ADDR_LINK_CAP) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_wr[p]) begin
          crc_flag_enable_ff[p] <= reg_wdata[CRC_FLAG_BIT];
        end
      end
    end
  end

  // (RULE7) embedded line count per port
  // Changing it mid-frame takes effect on the next long packet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        embed_count_ff[p] <= EMBED_COUNT_RESET;
      end
    end else if (reg_addr == ADDR_RAW_EMBED) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_wr[p]) begin
          embed_count_ff[p] <= reg_wdata[EMBED_COUNT_LSB +: 2];
        end
      end
    end
  end

  // (RULE8) embedded type value per port
  // Reset value marks the line as embedded non-image data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        embed_type_ff[p] <= EMBED_TYPE_RESET;
      end
    end else if (reg_addr == ADDR_RAW_EMBED) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_wr[p]) begin
          embed_type_ff[p] <= reg_wdata[5:0];
        end
      end
    end
  end

  // (RULE3) paged window bytes
  // Contents are plain storage here; status logic of other blocks overrides on read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int w = 0; w < PAGED_WORDS; w++) begin
          paged_ff[p][w] <= 8'h00;
        end
      end
    end else if (is_paged(reg_addr)) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_wr[p]) begin
          paged_ff[p][page_index(reg_addr)] <= reg_wdata;
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Answer strobe one cycle after each read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
    end
  end

  // (RULE1) read selector picks the copy
  // Data holds until the next read, so a slow front end may pick it up late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_RESERVED) begin
        // (RULE11) reads zero
        reg_rdata_ff <= RESERVED_VALUE;
      end else if (reg_addr == ADDR_PAGE_SEL) begin
        // (RULE5) arrival port
        reg_rdata_ff <= {(reg_remote ? reg_src_port : 2'h0), rd_port, wen_ff[src]};
      end else if (reg_addr == ADDR_LINK_CAP) begin
        reg_rdata_ff <= 8'(crc_flag_enable_ff[rd_port]) << CRC_FLAG_BIT;
      end else if (reg_addr == ADDR_RAW_EMBED) begin
        reg_rdata_ff <= {embed_count_ff[rd_port], embed_type_ff[rd_port]};
      end else if (reg_addr == ADDR_PORT_STS1) begin
        // (RULE12) selected port in status; other status bits belong elsewhere
        reg_rdata_ff <= {rd_port, 6'h00};
      end else if (is_paged(reg_addr)) begin
        // (RULE1) paged copy of the selected port
        reg_rdata_ff <= paged_ff[rd_port][page_index(reg_addr)];
      end else begin
        // Unmapped reads return zero
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // ****************************************
  // Embedded type substitution
  // ****************************************
  // (RULE8) type swap; (RULE9) never in CSI-2 mode
  // One decision per port, shared by the type and the flag registers
  always_comb begin
    swap = 4'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      swap[p] = long_pkt[p] && !csi2_mode[p] && (line_cnt_ff[p] < embed_count_ff[p]);
    end
  end

  // (RULE7) counts long packets since frame start
  // Frame start wins over a packet in the same cycle; that packet uses the old count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        line_cnt_ff[p] <= 2'h0;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (frame_start[p]) begin
          line_cnt_ff[p] <= 2'h0;
        end else if (long_pkt[p] && line_cnt_ff[p] != LINE_CNT_MAX) begin
          line_cnt_ff[p] <= line_cnt_ff[p] + LINE_CNT_STEP;
        end
      end
    end
  end

  // (RULE8) type handed on with each packet
  // Raw type passes through untouched when no substitution applies
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pkt_type_ff[p] <= 6'h00;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (swap[p]) begin
          pkt_type_ff[p] <= embed_type_ff[p];
        end else begin
          pkt_type_ff[p] <= raw_type_in[p];
        end
      end
    end
  end

  // (RULE9) flag marks substituted packets only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pkt_embedded_ff <= 4'h0;
    end else begin
      pkt_embedded_ff <= swap;
    end
  end
endmodule

// ===== testbench/rx_page_asserts.sv
// Checker for the paging slice, bound onto the design top.
// Assumes checker port names equal the design port names.
`timescale 1ns/1ps
module rx_page_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic reg_remote,
  input wire logic [1:0] reg_src_port,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff,
  input wire logic [3:0] csi2_mode,
  input wire logic [3:0] long_pkt,
  input wire logic [3:0] pkt_embedded_ff
);
  // Reads of the page select register only
  wire logic sel_rd = reg_rd && reg_addr == 8'h4C;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (reg_rd |=> reg_rvalid_ff) else $error("no answer");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid_ff) else $error("stray rvalid");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_ff)) else $error("rdata moved");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'h49 |=>
    reg_rdata_ff == 8'h00)
    else $error("0x49 not zero");
  a_local_port: assert property (sel_rd && !reg_remote |=> reg_rdata_ff[7:6] == 2'h0)
    else $error("local arrival not 0");
  a_remote_port: assert property (sel_rd && reg_remote |=>
    reg_rdata_ff[7:6] == $past(reg_src_port))
    else $error("remote arrival wrong");
  a_csi_plain: assert property ((long_pkt & csi2_mode) != 0 |=>
    (pkt_embedded_ff & $past(long_pkt & csi2_mode)) == 0) else $error("csi2 packet substituted");
  a_status_low: assert property (reg_rd && reg_addr == 8'h4D |=>
    reg_rdata_ff[5:0] == 6'h00)
    else $error("status low bits set");
endmodule
bind rx_port_page_select_regs rx_page_asserts i_chk (.*);

// ===== testbench/reg_host.sv
// Register host model: local I2C or control-channel source.
// Assumes one access at a time, strobe held across one sampling edge.
`timescale 1ns/1ps
module reg_host (
  input wire logic clk,
  output logic rd,
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic remote,
  output logic [1:0] port
);
  initial {rd, wr, addr, wdata, remote, port} = '0;
  // Released address and data lines show inverted values, strobes drop low, so stale data never looks valid
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d, input logic m,
                     input logic [1:0] p);
    @(posedge clk);
    #1 {rd, wr, addr, wdata, remote, port} = {r, !r, a, d, m, p};
    @(posedge clk);
    #1 {rd, wr, addr, wdata} = {2'b00, ~a, ~d};
  endtask
endmodule

// ===== testbench/rx_port_page_select_regs_test.sv
// Bench comparing the paging slice with a per-source page model.
// Assumes reg_host drives the register port.
`timescale 1ns/1ps
module rx_port_page_select_regs_test;
  import rx_page_pkg::*;
  logic clk = 0, rst_n = 0, rd, wr, rm, rvalid;
  logic [1:0] sp;
  logic [7:0] addr, wdata, rdata, pa, d;
  logic [3:0] csi2_mode = 0, frame_start = 0, long_pkt = 0, emb, cap;
  logic [5:0] raw_in [NUM_PORTS] = '{default: 0};
  logic [5:0] ptype [NUM_PORTS];
  logic [5:0] t;
  logic [1:0] sel [5];
  logic [3:0] wen [5];
  logic [7:0] mem [4][256];
  int mismatches = 0, checks = 0, s;
  initial forever #2.5 clk = ~clk;
  reg_host h (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .remote(rm), .port(sp));
  rx_port_page_select_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_remote(rm), .reg_src_port(sp), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(rvalid), .csi2_mode(csi2_mode), .frame_start(frame_start), .long_pkt(long_pkt),
    .raw_type_in(raw_in), .pkt_type_ff(ptype), .pkt_embedded_ff(emb), .crc_flag_enable_ff(cap));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    checks++;
    if (v !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  // Write through a source and update the model pages of the ports that source enables
  task automatic wrm(input int q, input logic [7:0] a, input logic [7:0] x);
    h.acc(0, a, x, q > 0, 2'(q - 1));
    if (a == 8'h4C) {sel[q], wen[q]} = x[5:0];
    else if (a == 8'h4A || a == 8'h4B || (a > 8'h4D && a < 8'h80) || (a >= 8'hD0 && a <= 8'hDF))
      for (int p = 0; p < 4; p++) if (wen[q][p]) mem[p][a] = x;
  endtask
  task automatic rdm(input int q, input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h4C) ? {(q > 0) ? 2'(q - 1) : 2'h0, sel[q], wen[q]} : (a == 8'h4D) ?
      {sel[q], 6'h00} : (a == 8'h4A) ? mem[sel[q]][a] & 8'h10 : mem[sel[q]][a];
    h.acc(1, a, 8'h00, q > 0, 2'(q - 1));
    chk("rdata", e, rdata);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: the full run needs about 455 cycles
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(89));
    foreach (mem[p, a]) mem[p][a] = (a == 'h4B) ? 8'h12 : 8'h00;
    foreach (sel[q]) {sel[q], wen[q]} = q ? {2'(q - 1), 4'(1 << (q - 1))} : 6'h00;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    for (s = 0; s < 5; s++) foreach (ADDR_RESERVED[i]) if (i < 6) rdm(s, 8'h49 + 8'(i) + (i == 5) * 8'h32);
    for (int i = 0; i < 12; i++) begin
      s = $urandom % 5;
      d = i ? 8'($urandom % 16) : 8'h00;
      pa = (i % 4 == 1) ? 8'h4A : (i % 4 == 2) ? 8'h49 : 8'h4E + 8'($urandom % 50);
      if (i % 4 == 3) pa = 8'hD0 + 8'($urandom % 16);
      wrm(s, 8'h4C, d);
      wrm(s, pa, 8'($urandom));
      for (int p = 0; p < 4; p++) begin
        wrm(s, 8'h4C, {2'h0, 2'(p), d[3:0]});
        rdm(s, pa);
        rdm(s, 8'h4D);
      end
    end
    wrm(0, 8'h4C, 8'h0F);
    wrm(0, 8'h4E, 8'hA5);
    wrm(0, 8'hDE, 8'h5A);
    rdm(0, 8'h4E);
    rdm(0, 8'hDE);
    for (s = 0; s < 5; s++) rdm(s, 8'h4C);
    wrm(0, 8'h4C, 8'h0F);
    wrm(0, 8'h4A, 8'hFF);
    chk("cap", 8'h0F, 8'(cap));
    csi2_mode = 4'h2;
    for (int k = 0; k < 4; k++) begin
      t = 6'($urandom);
      wrm(0, 8'h4B, {2'(k), t});
      @(posedge clk);
      #1 frame_start = 4'hF;
      @(posedge clk);
      #1 frame_start = 4'h0;
      for (int n = 0; n < 4; n++) begin
        raw_in[0] = 6'($urandom);
        raw_in[1] = 6'($urandom);
        long_pkt = 4'h3;
        @(posedge clk);
        #1 long_pkt = 4'h0;
        chk("embed0", 8'(n < k), 8'(emb[0]));
        chk("type0", 8'((n < k) ? t : raw_in[0]), 8'(ptype[0]));
        chk("embed1", 8'h00, 8'(emb[1]));
        chk("type1", 8'(raw_in[1]), 8'(ptype[1]));
      end
    end
    stop_test();
  end
endmodule
